// ==== rtl/bcpm_core.sv ====
// charge monitor core: counters, power states, result formatting
// assumes a serial engine on clk_sys presents byte register accesses
// and a sleep command pulse; pins and converter pulses are asynchronous
`timescale 1ns/1ps
`include "bcpm_regs.svh"

module bcpm_core #(
    parameter int TICK_CYCLES = `TIME_TICK_NS / `CLK_PERIOD_NS,
    parameter logic [7:0] GAIN_TRIM = 8'h00  // arbitrary factory value
) (
    input  wire logic        clk_sys,        // 200 MHz system clock
    input  wire logic        reset_n,        // synchronous reset
    input  wire logic [6:0]  regAddr,        // register byte address
    input  wire logic        regWrite,       // write strobe
    input  wire logic        regRead,        // read strobe
    input  wire logic [7:0]  regWrData,      // write byte
    output logic      [7:0]  regRdData,      // read byte, next cycle
    input  wire logic        sleepCmd,       // sleep command pulse
    input  wire logic        hostLine,       // single-wire line level
    input  wire logic        porLow,         // supply below threshold
    input  wire logic        vfcPulse,       // converter count pulse
    input  wire logic        senseNeg,       // sense polarity negative
    input  wire logic [12:0] senseMagUv,     // sense magnitude, uV
    input  wire logic [10:0] dieTempK,       // die temperature, kelvin
    input  wire logic [10:0] batResult,      // battery voltage code
    input  wire logic [4:0]  batOffset,      // sign and magnitude
    output logic             clockRun,       // internal clock enabled
    output logic             autoZero,       // shorts sense for offset
    output logic             selfWake,       // brief sleep wake
    output logic [2:0]       powerState      // current power state
);

    // ********************
    // input synchronisers
    // ********************
    logic lineMeta, lineSync, lineLast;
    logic porMeta, porSync;
    logic vfcMeta, vfcSync, vfcLast;
    logic negMeta, negSync;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            lineMeta <= 1'b1;  // line idles high: no false edge
            lineSync <= 1'b1;
            lineLast <= 1'b1;
            porMeta  <= 1'b0;
            porSync  <= 1'b0;
            vfcMeta  <= 1'b0;
            vfcSync  <= 1'b0;
            vfcLast  <= 1'b0;
            negMeta  <= 1'b0;
            negSync  <= 1'b0;
        end else begin
            lineMeta <= hostLine;
            lineSync <= lineMeta;
            lineLast <= lineSync;
            porMeta  <= porLow;
            porSync  <= porMeta;
            vfcMeta  <= vfcPulse;
            vfcSync  <= vfcMeta;
            vfcLast  <= vfcSync;
            negMeta  <= senseNeg;
            negSync  <= negMeta;
        end
    end

    logic lineEdge, vfcEdge;
    assign lineEdge = lineSync ^ lineLast;
    assign vfcEdge  = vfcSync & ~vfcLast;

    // ********************
    // power state machine
    // ********************
    bcpm_pkg::bcpm_state_type state, next_state;
    logic [2:0]  wakeSel;
    logic        fastTick;
    logic        belowWake;

    // threshold in microvolts for each wake select code
    function automatic logic [12:0] wakeLimit(input logic [2:0] code);
        case (code)
            3'h1:    wakeLimit = 13'h0dbc;
            3'h2:    wakeLimit = 13'h06de;
            3'h3:    wakeLimit = 13'h0494;
            3'h4:    wakeLimit = 13'h036f;
            3'h5:    wakeLimit = 13'h02bf;
            3'h6:    wakeLimit = 13'h024a;
            3'h7:    wakeLimit = 13'h01f6;
            default: wakeLimit = 13'h0000;
        endcase
    endfunction

    // code zero turns the gate off, so sleep follows the command at once
    assign belowWake = (wakeSel == 3'h0) ||
                       (senseMagUv < wakeLimit(wakeSel));  // [R5]

    always_comb begin
        next_state = state;
        case (state)
            bcpm_pkg::ST_NORMAL: begin
                if (sleepCmd)
                    next_state = bcpm_pkg::ST_SLEEP_PEND;
            end
            bcpm_pkg::ST_SLEEP_PEND: begin
                if (lineEdge)
                    next_state = bcpm_pkg::ST_NORMAL;
                else if (belowWake)
                    next_state = bcpm_pkg::ST_SLEEP;       // [R1]
            end
            bcpm_pkg::ST_SLEEP: begin
                if (lineEdge)
                    next_state = bcpm_pkg::ST_NORMAL;      // [R4]
                else if (fastTick)
                    next_state = bcpm_pkg::ST_SELF_WAKE;   // [R3]
            end
            bcpm_pkg::ST_SELF_WAKE: begin
                if (lineEdge)
                    next_state = bcpm_pkg::ST_NORMAL;
                else
                    next_state = bcpm_pkg::ST_SLEEP;       // [R3]
            end
            bcpm_pkg::ST_HIBERNATE: begin
                if (!porSync)
                    next_state = bcpm_pkg::ST_NORMAL;      // [R12]
            end
            default: next_state = bcpm_pkg::ST_NORMAL;
        endcase
        // supply loss overrides every other state
        if (porSync)
            next_state = bcpm_pkg::ST_HIBERNATE;           // [R12]
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state      <= bcpm_pkg::ST_NORMAL;
            clockRun   <= 1'b1;
            selfWake   <= 1'b0;
            powerState <= 3'h0;
        end else begin
            state      <= next_state;
            clockRun   <= (next_state == bcpm_pkg::ST_NORMAL) ||
                          (next_state == bcpm_pkg::ST_SLEEP_PEND); // [R1]
            selfWake   <= (next_state == bcpm_pkg::ST_SELF_WAKE);
            powerState <= next_state;
        end
    end

    logic runAll, runSelf;
    // acquisition continues while a sleep request waits for quiet
    assign runAll  = (state == bcpm_pkg::ST_NORMAL) ||
                     (state == bcpm_pkg::ST_SLEEP_PEND);      // [R6]
    assign runSelf = runAll || (state == bcpm_pkg::ST_SELF_WAKE); // [R6]

    // ********************
    // timebase
    // ********************
    logic [27:0] tickDiv;

    // the low-power oscillator keeps running except in hibernate
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tickDiv  <= 28'h0;
            fastTick <= 1'b0;
        end else if (state == bcpm_pkg::ST_HIBERNATE) begin
            fastTick <= 1'b0;
        end else if (tickDiv == 28'(TICK_CYCLES - 1)) begin
            tickDiv  <= 28'h0;
            fastTick <= 1'b1;
        end else begin
            tickDiv  <= tickDiv + 28'h1;
            fastTick <= 1'b0;
        end
    end

    // pending self-discharge ticks, consumed at the next brief wake
    logic [7:0] selfTicks;
    always_ff @(posedge clk_sys) begin
        if (!reset_n)
            selfTicks <= 8'h0;
        else if (runSelf)
            selfTicks <= 8'(fastTick);
        else if (fastTick && selfTicks != 8'hff)
            selfTicks <= selfTicks + 8'h1;
    end

    // ********************
    // offset cancellation
    // ********************
    logic [9:0]  azDiv;
    logic signed [11:0] offsetDebt;
    logic        countPulse;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            azDiv    <= 10'h0;
            autoZero <= 1'b0;
        end else begin
            azDiv    <= (azDiv == `AZ_PERIOD) ? 10'h0 : azDiv + 10'h1;
            autoZero <= runAll && (azDiv < `AZ_LENGTH);      // [R13]
        end
    end

    // pulses seen with the input shorted are offset; matching pulses
    // during measurement repay that debt instead of counting
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            offsetDebt <= 12'sh0;
        end else if (vfcEdge && autoZero) begin
            if (negSync && offsetDebt != -12'sh7ff)
                offsetDebt <= offsetDebt - 12'sh1;           // [R13]
            else if (!negSync && offsetDebt != 12'sh7ff)
                offsetDebt <= offsetDebt + 12'sh1;           // [R13]
        end else if (countPulse == 1'b0 && vfcEdge && runAll) begin
            if (negSync)
                offsetDebt <= offsetDebt + 12'sh1;
            else
                offsetDebt <= offsetDebt - 12'sh1;
        end
    end

    always_comb begin
        countPulse = vfcEdge && runAll && !autoZero;
        if (negSync && offsetDebt < 12'sh0)
            countPulse = 1'b0;                               // [R13]
        if (!negSync && offsetDebt > 12'sh0)
            countPulse = 1'b0;                               // [R13]
    end

    // ********************
    // self-discharge rate
    // ********************
    // weight in eighths of the nominal rate, doubling per 10 degrees
    function automatic logic [6:0] selfWeight(input logic [10:0] tk);
        if (tk < 11'h116)
            selfWeight = 7'h01;
        else if (tk < 11'h120)
            selfWeight = 7'h02;
        else if (tk < 11'h12a)
            selfWeight = 7'h04;
        else if (tk < 11'h134)
            selfWeight = 7'h08;
        else if (tk < 11'h13e)
            selfWeight = 7'h10;
        else if (tk < 11'h148)
            selfWeight = 7'h20;
        else
            selfWeight = 7'h40;
    endfunction

    logic [15:0] selfAcc;
    logic        selfInc;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            selfAcc <= 16'h0;
            selfInc <= 1'b0;
        end else if (runSelf && selfTicks != 8'h0) begin
            // one hour of nominal ticks at the nominal weight
            if ({1'b0, selfAcc} + {10'h0, selfWeight(dieTempK)}
                    >= {1'b0, `SELF_HOUR_TICKS}) begin
                selfAcc <= selfAcc + {9'h0, selfWeight(dieTempK)}
                           - `SELF_HOUR_TICKS;               // [R9]
                selfInc <= 1'b1;
            end else begin
                selfAcc <= selfAcc + {9'h0, selfWeight(dieTempK)};
                selfInc <= 1'b0;
            end
        end else begin
            selfInc <= 1'b0;
        end
    end

    // ********************
    // counter clear control and mode bits
    // ********************
    logic [4:0] clrPend;
    logic [1:0] slowFlag;     // 0 discharge time, 1 charge time
    logic [1:0] wrapHit;
    logic       timeClear;
    logic       wrClear, wrMode;

    assign wrClear   = regWrite && regAddr == `ADDR_CLEAR;
    assign wrMode    = regWrite && regAddr == `ADDR_MODE;
    assign timeClear = clrPend[`CLR_DIS_TIME] | clrPend[`CLR_CHG_TIME];

    // a pending bit clears its counter this cycle and drops itself;
    // a fresh write in the same cycle wins over that drop
    always_ff @(posedge clk_sys) begin
        if (!reset_n)
            clrPend <= 5'h0;
        else if (wrClear)
            clrPend <= regWrData[4:0];                       // [R14]
        else
            clrPend <= 5'h0;                                 // [R15]
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n)
            wakeSel <= 3'h0;
        else if (wrMode)
            wakeSel <= regWrData[`MODE_WAKE_LSB +: 3];       // [R5]
    end

    // a wrap in the clearing cycle still leaves its flag set
    always_ff @(posedge clk_sys) begin
        if (!reset_n)
            slowFlag <= 2'h0;
        else
            slowFlag <= (timeClear ? 2'h0 : slowFlag) | wrapHit; // [R16]
    end

    // ********************
    // counters: 0 discharge, 1 charge, 2 self, 3 dis time, 4 chg time
    // ********************
    bcpm_pkg::bcpm_count_type count [5];
    logic [4:0] countInc;
    logic [7:0] slowDiv [2];
    logic [1:0] timeStep;
    logic       active;

    assign active = senseMagUv != 13'h0;

    always_comb begin
        countInc[0] = countPulse && negSync;                 // [R7]
        countInc[1] = countPulse && !negSync;                // [R8]
        countInc[2] = selfInc;                               // [R9]
        countInc[3] = timeStep[0];                           // [R10]
        countInc[4] = timeStep[1];                           // [R11]
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_time
            logic dirOn;
            // time counters only run while their direction is active
            assign dirOn = runAll && active &&
                           (gi == 0 ? negSync : !negSync);
            assign timeStep[gi] = dirOn && fastTick &&
                (!slowFlag[gi] || slowDiv[gi] == `SLOW_DIVIDE); // [R23]
            assign wrapHit[gi] = timeStep[gi] &&
                                 !clrPend[gi + 3] &&
                                 count[gi + 3] == 16'hffff;   // [R23]
            always_ff @(posedge clk_sys) begin
                if (!reset_n || timeClear)
                    slowDiv[gi] <= 8'h0;                     // [R16]
                else if (dirOn && fastTick && slowFlag[gi])
                    slowDiv[gi] <= slowDiv[gi] + 8'h1;       // [R10]
            end
        end

        for (gi = 0; gi < 5; gi++) begin : g_count
            always_ff @(posedge clk_sys) begin
                if (!reset_n)
                    count[gi] <= 16'h0;
                else if (clrPend[gi])
                    count[gi] <= 16'h0;                      // [R14]
                else if (countInc[gi])
                    count[gi] <= count[gi] + 16'h1;          // [R6]
            end
        end
    endgenerate

    // ********************
    // register read path
    // ********************
    function automatic logic [7:0] readByte(input logic [6:0] addr);
        logic [6:0] rel;
        logic [2:0] idx;
        rel = addr - `ADDR_COUNT_BASE;
        idx = 3'(3'h4 - 3'(rel[6:1]));
        readByte = 8'h0;
        if (addr >= `ADDR_COUNT_BASE && addr <= `ADDR_COUNT_TOP) begin
            readByte = rel[0] ? count[idx][15:8] : count[idx][7:0];
        end else begin
            case (addr)
                `ADDR_TEMP_LOW:  readByte = dieTempK[7:0];   // [R17]
                `ADDR_TEMP_HIGH: readByte = {5'h0, dieTempK[10:8]};
                `ADDR_CLEAR:     readByte = {3'h0, clrPend}; // [R15]
                `ADDR_MODE: begin
                    readByte[`MODE_SLOW_CHG] = slowFlag[1];
                    readByte[`MODE_SLOW_DIS] = slowFlag[0];
                    readByte[`MODE_WAKE_LSB +: 3] = wakeSel;
                end
                `ADDR_VOLT_LOW:  readByte = batResult[7:0];  // [R19]
                // offset magnitude counts in OFFSET_STEP_MV steps
                `ADDR_VOLT_HIGH: readByte = {batOffset,
                                    batResult[10:8]};  // [R18] [R20] [R24]
                `ADDR_GAIN_TRIM: readByte = GAIN_TRIM;       // [R21]
                default:         readByte = 8'h0;
            endcase
        end
    endfunction

    // raw results only; correction is left to the host
    always_ff @(posedge clk_sys) begin
        if (!reset_n)
            regRdData <= 8'h0;
        else if (regRead)
            regRdData <= readByte(regAddr);                  // [R22]
    end

endmodule

// ==== rtl/bcpm_regs.svh ====
// register offsets, field positions and timing counts of the charge monitor
// assumes a 200 MHz system clock and a byte-wide register port
//
// Behaviour
// [R1] sleep only once activity below threshold
// [R2] host saves registers to flash first
// [R3] periodic brief wake updates self-discharge count
// [R4] any host line edge ends sleep
// [R5] 3-bit threshold code, zero disables
// [R6] counters active per power state
// [R7] discharge count advances on negative sense
// [R8] charge count advances on positive sense
// [R9] self-discharge hourly, temperature scaled
// [R10] discharge time rate, slow when flagged
// [R11] charge time rate, slow when flagged
// [R12] hibernate while supply below threshold
// [R13] sense offset cancelled continuously
// [R14] host writes one to clear counter
// [R15] clear bit returns to zero itself
// [R16] time clear drops both slow flags
// [R17] die temperature readable as byte pair
// [R18] battery voltage 11-bit unsigned result
// [R19] voltage bits split across 0x72, 0x71
// [R20] voltage offset sign-magnitude in high bits
// [R21] gain correction byte at 0x79
// [R22] host applies gain and offset correction
// [R23] time counter wrap sets flag, slows
// [R24] offset magnitude step is 8 mV
`ifndef BCPM_REGS_SVH
`define BCPM_REGS_SVH
`define ADDR_TEMP_LOW     7'h60
`define ADDR_TEMP_HIGH    7'h61
`define ADDR_CLEAR        7'h63
`define ADDR_MODE         7'h64
`define ADDR_COUNT_BASE   7'h65
`define ADDR_COUNT_TOP    7'h6e
`define ADDR_VOLT_LOW     7'h71
`define ADDR_VOLT_HIGH    7'h72
`define ADDR_GAIN_TRIM    7'h79
`define MODE_WAKE_LSB     1
`define MODE_SLOW_DIS     4
`define MODE_SLOW_CHG     5
`define CLR_DIS_TIME      3
`define CLR_CHG_TIME      4
`define OFFSET_STEP_MV    8
`define CLK_PERIOD_NS     5
`define TIME_TICK_NS      878_900_000
`define SLOW_DIVIDE       8'hff
`define SELF_HOUR_TICKS   16'h8000
`define AZ_PERIOD         10'h3ff
`define AZ_LENGTH         10'h040
`endif

// ==== rtl/bcpm_pkg.sv ====
// types shared by the charge monitor core
// assumes nothing of its surroundings
package bcpm_pkg;
    typedef enum logic [2:0] {
        ST_NORMAL     = 3'b000,
        ST_SLEEP_PEND = 3'b001,
        ST_SLEEP      = 3'b010,
        ST_SELF_WAKE  = 3'b011,
        ST_HIBERNATE  = 3'b100
    } bcpm_state_type;
    typedef logic [15:0] bcpm_count_type;
endpackage

// ==== dv/bcpm_core_props.sv ====
// concurrent checks on the charge monitor core ports
// assumes bcpm_core on one clock with a synchronous active-low reset
`timescale 1ns/1ps
module bcpm_core_props (
    input wire logic        clk_sys,    // system clock
    input wire logic        reset_n,    // synchronous reset
    input wire logic        sleepCmd,   // sleep command pulse
    input wire logic        hostLine,   // single-wire line level
    input wire logic        porLow,     // supply below threshold
    input wire logic        regRead,    // read strobe
    input wire logic [6:0]  regAddr,    // register address
    input wire logic [7:0]  regRdData,  // read byte
    input wire logic [10:0] batResult,  // voltage code
    input wire logic [4:0]  batOffset,  // voltage offset
    input wire logic        clockRun,   // internal clock enabled
    input wire logic        autoZero,   // offset window
    input wire logic        selfWake,   // brief wake pulse
    input wire logic [2:0]  powerState  // power state
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic [6:0]  azLen;
    logic [10:0] runLen;
    // a window only counts if acquisition ran long before it began
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !autoZero) azLen <= 7'h00;
        else azLen <= azLen + 7'h01;
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n || !clockRun) runLen <= 11'h000;
        else if (runLen != 11'h7ff) runLen <= runLen + 11'h001;
    end
    a_pend_needs_cmd: assert property (
        (powerState == 3'h1 && $past(powerState) == 3'h0) |-> $past(sleepCmd))
        else $error("sleep pending without a command");
    a_sleep_after_pend: assert property (
        powerState == 3'h2 |-> $past(powerState) != 3'h0)
        else $error("sleep entered straight from normal");
    a_clock_off_low: assert property (
        (powerState == 3'h2 || powerState == 3'h4) |-> !clockRun)
        else $error("clock running in low power state");
    a_brief_wake_short: assert property (
        (powerState == 3'h3 || selfWake) |=> (powerState != 3'h3 && !selfWake))
        else $error("brief wake lasted more than a cycle");
    a_edge_wakes_up: assert property (
        ($changed(hostLine) && powerState == 3'h2 && !porLow)
        |-> ##[1:8] powerState == 3'h0)
        else $error("line edge did not end sleep");
    a_por_hibernates: assert property (
        porLow [*6] |=> powerState == 3'h4)
        else $error("no hibernate on low supply");
    a_hibernate_holds: assert property (
        (powerState == 3'h4 && porLow) |=> powerState == 3'h4)
        else $error("hibernate left while supply low");
    a_autozero_length: assert property (
        ($fell(autoZero) && clockRun && runLen == 11'h7ff) |-> azLen == 7'h40)
        else $error("offset window length wrong");
    a_volt_low_read: assert property (
        (regRead && regAddr == 7'h71) |=> regRdData == $past(batResult[7:0]))
        else $error("voltage low byte wrong");
    a_volt_high_read: assert property (
        (regRead && regAddr == 7'h72) |=>
        regRdData == {$past(batOffset), $past(batResult[10:8])})
        else $error("voltage high byte wrong");
endmodule
bind bcpm_core bcpm_core_props u_props (.clk_sys, .reset_n, .sleepCmd,
    .hostLine, .porLow, .regRead, .regAddr, .regRdData, .batResult,
    .batOffset, .clockRun, .autoZero, .selfWake, .powerState);

// ==== dv/bcpm_host_model.sv ====
// host controller model: register accesses, sleep command, line edges
// tasks are entered and left 1 ns after a rising clock edge
`timescale 1ns/1ps
module bcpm_host_model #(
    parameter logic [7:0] SAVE_CMD = 8'h01  // flash save command code
) (
    input  wire logic       clk_sys,    // system clock
    input  wire logic [7:0] regRdData,  // read byte from the core
    output logic      [6:0] regAddr,    // register address
    output logic            regWrite,   // write strobe
    output logic            regRead,    // read strobe
    output logic      [7:0] regWrData,  // write byte
    output logic            sleepCmd,   // sleep command pulse
    output logic            hostLine    // line level, idles high
);
    initial begin
        regAddr = 7'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWrData = 8'h00;
        sleepCmd = 1'b0;
        hostLine = 1'b1;
    end
    // released fields go to the inverse so stale values are never seen
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(posedge clk_sys);
        #1;
        regWrite = 1'b0;
        regWrData = ~d;
        regAddr = ~a;
        // idle edge so a following call never re-drives in this step
        @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        regAddr = a;
        regRead = 1'b1;
        @(posedge clk_sys);
        #1;
        regRead = 1'b0;
        regAddr = ~a;
        d = regRdData;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic sleep_req();
        wr(7'h62, SAVE_CMD);
        sleepCmd = 1'b1;
        @(posedge clk_sys);
        #1;
        sleepCmd = 1'b0;
    endtask
    task automatic toggle();
        hostLine = ~hostLine;
    endtask
endmodule

// ==== dv/tb_battery_counter_power_modes.sv ====
// self-checking bench for the charge monitor core
// assumes the host model drives the register port and line
`timescale 1ns/1ps
module tb_battery_counter_power_modes;
    logic clk_sys = 1'b0;
    logic reset_n, porLow, vfcPulse, senseNeg;
    logic [12:0] senseMagUv;
    logic [10:0] dieTempK, batResult;
    logic [4:0]  batOffset;
    logic [6:0]  regAddr;
    logic [7:0]  regWrData, regRdData;
    logic regWrite, regRead, sleepCmd, hostLine;
    logic clockRun, autoZero, selfWake;
    logic [2:0]  powerState;
    int mismatches = 0;
    int n_checks = 0;
    localparam logic [12:0] LIMITS [8] = '{13'h1fff, 13'hdbc, 13'h6de,
        13'h494, 13'h36f, 13'h2bf, 13'h24a, 13'h1f6};
    always #2.5 clk_sys = ~clk_sys;
    bcpm_core #(.TICK_CYCLES(20), .GAIN_TRIM(8'hf6)) dut (.clk_sys,
        .reset_n, .regAddr, .regWrite, .regRead, .regWrData, .regRdData,
        .sleepCmd, .hostLine, .porLow, .vfcPulse, .senseNeg, .senseMagUv,
        .dieTempK, .batResult, .batOffset, .clockRun, .autoZero,
        .selfWake, .powerState);
    bcpm_host_model host (.clk_sys, .regRdData, .regAddr, .regWrite,
        .regRead, .regWrData, .sleepCmd, .hostLine);
    task automatic stop_test();
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic rd16(input logic [6:0] a, output logic [15:0] v);
        host.rd(a, v[7:0]);
        host.rd(a + 7'h01, v[15:8]);
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            vfcPulse = 1'b1;
            cyc(4);
            vfcPulse = 1'b0;
            cyc(4);
        end
    endtask
    task automatic wait_state(input logic [2:0] e);
        for (int i = 0; i < 400 && powerState !== e; i++) cyc(1);
        chk("powerState", 16'(e), 16'(powerState));
    endtask
    // counts are pulsed only outside the offset window so none are repaid
    task automatic count_run(input logic neg, input int n);
        senseNeg = neg;
        @(negedge autoZero);
        cyc(4);
        senseMagUv = 13'h3e8;
        pulses(n);
        cyc(20);
        senseMagUv = 13'h0000;
        cyc(4);
    endtask
    initial begin
        #(5 * 80000);
        mismatches++;
        stop_test();
    end
    initial begin
        logic [15:0] v;
        logic [7:0]  b;
        int cnt [2];
        int seen;
        reset_n = 1'b0;
        porLow = 1'b0;
        vfcPulse = 1'b0;
        senseNeg = 1'b0;
        senseMagUv = 13'h0000;
        dieTempK = 11'h12a;
        batResult = 11'h000;
        batOffset = 5'h00;
        v = 16'($urandom(1));
        cyc(20);
        reset_n = 1'b1;
        cyc(1);
        chk("clockRun", 16'h0001, 16'(clockRun));
        repeat (8) begin
            batResult = 11'($urandom);
            batOffset = 5'($urandom);
            dieTempK = 11'($urandom);
            cyc(1);
            host.rd(7'h71, b);
            chk("volt_low", 16'(batResult[7:0]), 16'(b));
            host.rd(7'h72, b);
            chk("volt_high", 16'({batOffset, batResult[10:8]}),
                16'(b));
            host.rd(7'h60, b);
            chk("temp_low", 16'(dieTempK[7:0]), 16'(b));
            host.rd(7'h61, b);
            chk("temp_high", 16'(dieTempK[10:8]), 16'(b));
        end
        host.rd(7'h79, b);
        chk("gain_trim", 16'h00f6, 16'(b));
        dieTempK = 11'h12a;
        for (int p = 0; p < 2; p++) begin
            cnt[p] = $urandom_range(20, 1);
            count_run(p[0], cnt[p]);
        end
        rd16(7'h6b, v);
        chk("charge_count", 16'(cnt[0]), v);
        rd16(7'h6d, v);
        chk("discharge_count", 16'(cnt[1]), v);
        rd16(7'h65, v);
        chk("charge_time_run", 16'h0001, 16'(v != 16'h0000));
        rd16(7'h67, v);
        chk("dis_time_run", 16'h0001, 16'(v != 16'h0000));
        host.wr(7'h63, 8'h02);
        cyc(2);
        rd16(7'h6b, v);
        chk("charge_cleared", 16'h0000, v);
        rd16(7'h6d, v);
        chk("discharge_kept", 16'(cnt[1]), v);
        host.wr(7'h63, 8'h1f);
        cyc(2);
        host.rd(7'h63, b);
        chk("clear_bits", 16'h0000, 16'(b));
        for (int a = 'h65; a < 'h6f; a += 2) begin
            rd16(7'(a), v);
            chk("counter_zero", 16'h0000, v);
        end
        host.rd(7'h64, b);
        chk("slow_flags", 16'h0000, 16'(b[5:4]));
        senseNeg = 1'b0;
        for (int c = 0; c < 8; c++) begin
            host.wr(7'h64, 8'(c << 1));
            host.rd(7'h64, b);
            chk("wake_select", 16'(c), 16'(b[3:1]));
            senseMagUv = LIMITS[c];
            host.sleep_req();
            cyc(12);
            if (c != 0) begin
                chk("pending", 16'h0001, 16'(powerState));
                senseMagUv = LIMITS[c] - 13'h0001;
            end
            wait_state(3'h2);
            chk("clock_stopped", 16'h0000, 16'(clockRun));
            senseMagUv = 13'h0000;
            seen = 0;
            for (int i = 0; i < 200 && !seen; i++) begin
                cyc(1);
                seen = (selfWake === 1'b1);
            end
            chk("self_wake", 16'h0001, 16'(seen));
            pulses($urandom_range(5, 1));
            host.toggle();
            wait_state(3'h0);
            rd16(7'h6b, v);
            chk("sleep_no_count", 16'h0000, v);
        end
        count_run(1'b0, 3);
        porLow = 1'b1;
        wait_state(3'h4);
        pulses(4);
        porLow = 1'b0;
        wait_state(3'h0);
        rd16(7'h6b, v);
        chk("hibernate_kept", 16'h0003, v);
        stop_test();
    end
endmodule
